// ### dsg_pkg.sv
// Constants shared by the debug-shared GPIO port and its bus slave.
// Assumes byte addresses on the register bus, one aligned word each.
package dsg_pkg;

  // Register window
  localparam logic [31:0] DSG_BASE   = 32'h400C_0800;
  localparam int          ADDR_W     = 6;
  localparam int          NPINS      = 8;
  localparam int          OD_PINS    = 3;

  // Byte offsets inside the window
  localparam logic [5:0] OFS_LEVEL = 6'h00;
  localparam logic [5:0] OFS_DRIVE = 6'h04;
  localparam logic [5:0] OFS_ALT   = 6'h08;
  localparam logic [5:0] OFS_OD    = 6'h28;
  localparam logic [5:0] OFS_PU    = 6'h2C;
  localparam logic [5:0] OFS_PD    = 6'h30;
  localparam logic [5:0] OFS_IE    = 6'h38;

  // Reset values and implemented-bit masks
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam logic [7:0] DRIVE_RST = 8'h30;
  localparam logic [7:0] ALT_RST   = 8'hF8;
  localparam logic [2:0] OD_RST    = 3'h0;
  localparam logic [7:0] PU_RST    = 8'hD0;
  localparam logic [7:0] PU_MASK   = 8'hF7;
  localparam logic       PD_RST    = 1'b1;
  localparam logic [7:0] IE_RST    = 8'hD8;

  // Pin roles when the alternate function is selected
  localparam int PIN_TRD1  = 0;
  localparam int PIN_TRD0  = 1;
  localparam int PIN_TRCLK = 2;
  localparam int PIN_TCK   = 3;
  localparam int PIN_SWDIO = 4;
  localparam int PIN_TDO   = 5;
  localparam int PIN_TDI   = 6;
  localparam int PIN_TRST  = 7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### dsg_axil_slave.sv
// AXI4-Lite slave front end for the debug-shared GPIO port.
// Assumes the parent decodes addresses and supplies read data
// combinationally from rd_addr.
`timescale 1ns/1ns
module dsg_axil_slave
  import dsg_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   wr_pulse,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);

  // Write fires once both halves are held and no response is pending
  assign wr_pulse = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign rd_addr  = s_axi_araddr;

  // Write address and data are caught independently, in either order
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        wr_addr       <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_pulse) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: data captured at the address handshake
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### dsg_port.sv
// Eight-pin GPIO port shared with the debug access and trace pins.
// Assumes pads, debug core and stop-mode inputs are synchronous to
// mclk; pad wires are resolved outside from pad_out and pad_oe.
//
// How it works
// R1 - Eight pins, direction set per bit
// R2 - Pins switchable to debug or trace function
// R3 - Pins three to seven debug after reset
// R4 - Pin seven TRST, input and pull-up on
// R5 - Pin six TDI, input and pull-up on
// R6 - Pin three debug clock, input, pull-down on
// R7 - Pin four SWDIO, input, drive, pull-up on
// R8 - Pin five TDO, output driver on
// R9 - Pins zero to two plain, all disabled
// R10 - Debug pins four, five drive in deep stop
// R11 - Software frees pin three when clock unused
// R12 - Data, drive, function at 0, 4, 8
// R13 - Open-drain, pulls, input enable offsets
// R14 - Software avoids reserved offsets
// R15 - Data bits 7-0, upper bits read zero
// R16 - Drive enable per pin, pins 5,4 reset one
// R17 - Function bit: 0 port, 1 debug/trace
// R18 - Open-drain only on pins 2 to 0
// R19 - Pull-down only on pin three, reset on
// R20 - Input enable per pin, 7,6,4,3 reset on
// R21 - Port mode drives data; input reads pin
// R22 - Disabled input hides pin level
`timescale 1ns/1ns
module dsg_port
  import dsg_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  input  wire logic [NPINS-1:0]  pad_in,
  output logic [NPINS-1:0]       pad_out,
  output logic [NPINS-1:0]       pad_oe,
  output logic [NPINS-1:0]       pad_pu,
  output logic [NPINS-1:0]       pad_pd,
  output logic                   dbg_tck,
  output logic                   dbg_tms,
  output logic                   dbg_tdi,
  output logic                   dbg_trst_n,
  input  wire logic              dbg_swdio_out,
  input  wire logic              dbg_swdio_oe,
  input  wire logic              dbg_tdo,
  input  wire logic              trace_clk,
  input  wire logic [1:0]        trace_data,
  input  wire logic              deep_stop_mode,
  input  wire logic              standby_drive_enable
);

  logic [NPINS-1:0]   port_pin_level;
  logic [NPINS-1:0]   port_drive_enable;
  logic [NPINS-1:0]   port_alt_select;
  logic [OD_PINS-1:0] port_open_drain_sel;
  logic [NPINS-1:0]   port_pullup_sel;
  logic               port_pulldown_sel;
  logic [NPINS-1:0]   port_input_enable;
  logic [NPINS-1:0]   pin_sample;
  logic [NPINS-1:0]   next_out;
  logic [NPINS-1:0]   next_oe;
  logic [NPINS-1:0]   od_wide;
  logic               wr_pulse;
  logic [ADDR_W-1:0]  wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic [ADDR_W-1:0]  rd_addr;
  logic [31:0]        rd_data;
  logic               wr_lane0;

  // Offsets that hold a register; reserved ones answer with an error
  function automatic logic dsg_mapped(input logic [ADDR_W-1:0] a);
    dsg_mapped = (a == OFS_LEVEL) || (a == OFS_DRIVE) ||
                 (a == OFS_ALT) || (a == OFS_OD) || (a == OFS_PU) ||
                 (a == OFS_PD) || (a == OFS_IE); // see R12 see R13
  endfunction

  dsg_axil_slave u_bus (
    .mclk          (mclk),
    .nrst          (nrst),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .wr_pulse      (wr_pulse),
    .wr_addr       (wr_addr),
    .wr_data       (wr_data),
    .wr_strb       (wr_strb),
    .wr_ok         (dsg_mapped(wr_addr)),
    .rd_addr       (rd_addr),
    .rd_data       (rd_data),
    .rd_ok         (dsg_mapped(rd_addr))
  );

  // Only byte lane 0 carries implemented bits
  assign wr_lane0 = wr_pulse && wr_strb[0];
  assign od_wide  = {{(NPINS-OD_PINS){1'b0}}, port_open_drain_sel};

  // Configuration registers; reset puts pins 3-7 on the debug port
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      port_pin_level      <= LEVEL_RST;
      port_drive_enable   <= DRIVE_RST;  // see R16 see R7 see R8
      port_alt_select     <= ALT_RST;    // see R3 see R9
      port_open_drain_sel <= OD_RST;
      port_pullup_sel     <= PU_RST;     // see R4 see R5 see R7
      port_pulldown_sel   <= PD_RST;     // see R6 see R19
      port_input_enable   <= IE_RST;     // see R20 see R6
    end else if (wr_lane0) begin
      case (wr_addr)
        OFS_LEVEL: port_pin_level    <= wr_data[NPINS-1:0]; // see R15
        OFS_DRIVE: port_drive_enable <= wr_data[NPINS-1:0]; // see R1
        OFS_ALT:   port_alt_select   <= wr_data[NPINS-1:0]; // see R17
        OFS_OD:    port_open_drain_sel <= wr_data[OD_PINS-1:0];
        OFS_PU:    port_pullup_sel <= wr_data[NPINS-1:0] & PU_MASK;
        OFS_PD:    port_pulldown_sel <= wr_data[PIN_TCK];
        OFS_IE:    port_input_enable <= wr_data[NPINS-1:0];
        default: ;
      endcase
    end
  end

  // Read mux: narrow registers sit at their pin bits, upper bits return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      OFS_LEVEL: rd_data[NPINS-1:0] = pin_sample |
                   (port_pin_level & ~port_input_enable); // see R21
      OFS_DRIVE: rd_data[NPINS-1:0] = port_drive_enable;
      OFS_ALT:   rd_data[NPINS-1:0] = port_alt_select;
      OFS_OD:    rd_data[OD_PINS-1:0] = port_open_drain_sel; // see R18
      OFS_PU:    rd_data[NPINS-1:0] = port_pullup_sel;
      OFS_PD:    rd_data[PIN_TCK] = port_pulldown_sel;
      OFS_IE:    rd_data[NPINS-1:0] = port_input_enable;
      default:   rd_data = 32'h0000_0000;
    endcase
  end

  // Input path gated per pin so a pad whose input enable is off never reaches software
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pin_sample <= '0;
    end else begin
      pin_sample <= pad_in & port_input_enable; // see R22 see R21
    end
  end

  // Debug core inputs; idle levels whenever the pin is not lent out
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      dbg_tck    <= 1'b0;
      dbg_tms    <= 1'b1;
      dbg_tdi    <= 1'b1;
      dbg_trst_n <= 1'b1;
    end else begin
      dbg_tck <= port_alt_select[PIN_TCK] &&
                 port_input_enable[PIN_TCK] && pad_in[PIN_TCK]; // see R6
      dbg_tms <= !port_alt_select[PIN_SWDIO] ||
                 (port_input_enable[PIN_SWDIO] && pad_in[PIN_SWDIO]);
      dbg_tdi <= !port_alt_select[PIN_TDI] ||
                 (port_input_enable[PIN_TDI] && pad_in[PIN_TDI]); // see R5
      dbg_trst_n <= !port_alt_select[PIN_TRST] ||
                 (port_input_enable[PIN_TRST] && pad_in[PIN_TRST]);
    end
  end

  // Per-pin output source, driver enable and stop-mode gating
  always_comb begin
    logic fn;
    logic en;
    logic ov;
    logic keep;
    fn = 1'b0;
    en = 1'b0;
    ov = 1'b0;
    keep = 1'b0;
    next_out = '0;
    next_oe  = '0;
    for (int i = 0; i < NPINS; i++) begin
      fn   = port_alt_select[i];                     // see R2 see R17
      en   = port_drive_enable[i];                   // see R1
      ov   = port_pin_level[i];                      // see R21
      keep = 1'b0;
      if (fn) begin
        case (i)
          PIN_SWDIO: begin
            ov   = dbg_swdio_out;
            en   = en && dbg_swdio_oe;               // see R7
            keep = 1'b1;
          end
          PIN_TDO: begin
            ov   = dbg_tdo;                          // see R8
            keep = 1'b1;
          end
          PIN_TRCLK: ov = trace_clk;
          PIN_TRD0:  ov = trace_data[0];
          PIN_TRD1:  ov = trace_data[1];
          default:   en = 1'b0;                      // debug inputs
        endcase
      end else if (od_wide[i]) begin
        // Open-drain only sinks; a high level is left to the pull-up
        en = en && !ov;                              // see R18
        ov = 1'b0;
      end
      // Deep stop floats drivers unless held, debug pins excepted
      if (deep_stop_mode && !standby_drive_enable && !keep) begin
        en = 1'b0;                                   // see R10
      end
      next_out[i] = ov;
      next_oe[i]  = en;
    end
  end

  // Pad drive registered so pins never glitch on decode changes
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pad_out <= '0;
      pad_oe  <= '0;
      pad_pu  <= '0;
      pad_pd  <= '0;
    end else begin
      pad_out <= next_out;
      pad_oe  <= next_oe;
      pad_pu  <= port_pullup_sel;                    // see R4 see R9
      pad_pd  <= {{(NPINS-PIN_TCK-1){1'b0}}, port_pulldown_sel,
                  {PIN_TCK{1'b0}}};                  // see R19
    end
  end

  // Checks on the block's registers and outputs
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_alt_reset;
    $rose(nrst) |-> port_alt_select == ALT_RST;
  endproperty
  a_alt_reset: assert property (p_alt_reset) // see R3
    else $error("function select wrong after reset");

  property p_pull_reset;
    $rose(nrst) |=> pad_pu == PU_RST && pad_pd[PIN_TCK] &&
                    port_input_enable == IE_RST;
  endproperty
  a_pull_reset: assert property (p_pull_reset) // see R4
    else $error("pull or input enable wrong after reset");

  property p_drive_reset;
    $rose(nrst) |-> port_drive_enable == DRIVE_RST;
  endproperty
  a_drive_reset: assert property (p_drive_reset) // see R16
    else $error("drive enable wrong after reset");

  property p_rdata_upper;
    s_axi_rvalid |-> s_axi_rdata[31:NPINS] == '0;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) // see R15
    else $error("upper read bits not zero");

  property p_stop_keep;
    deep_stop_mode && port_alt_select[PIN_TDO] &&
    port_drive_enable[PIN_TDO] |=> pad_oe[PIN_TDO];
  endproperty
  a_stop_keep: assert property (p_stop_keep) // see R10
    else $error("debug output dropped in deep stop");

  property p_port_drive;
    !port_alt_select[PIN_TRST] && port_drive_enable[PIN_TRST] &&
    !deep_stop_mode |=> pad_oe[PIN_TRST] &&
    pad_out[PIN_TRST] == $past(port_pin_level[PIN_TRST]);
  endproperty
  a_port_drive: assert property (p_port_drive) // see R21
    else $error("port pin not driven from data");

  property p_input_block;
    !port_input_enable[PIN_TDI] |=> !pin_sample[PIN_TDI] &&
      (!dbg_tdi || !$past(port_alt_select[PIN_TDI]));
  endproperty
  a_input_block: assert property (p_input_block) // see R22
    else $error("disabled input leaked");

  property p_write_drive;
    wr_lane0 && wr_addr == OFS_DRIVE |=>
      port_drive_enable == $past(wr_data[NPINS-1:0]) && s_axi_bvalid;
  endproperty
  a_write_drive: assert property (p_write_drive) // see R12
    else $error("drive enable write not taken");

  property p_pd_only;
    pad_pd[NPINS-1:PIN_TCK+1] == '0 && pad_pd[PIN_TCK-1:0] == '0;
  endproperty
  a_pd_only: assert property (p_pd_only) // see R19
    else $error("pull-down outside pin three");

endmodule

// ### dsg_probe_model.sv
// Board and probe model for the debug-shared port: resolves each pad.
// Assumes the bench owns the probe's own drivers through ext_en/ext_val.
`timescale 1ns/1ns
module dsg_probe_model
  import dsg_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic [NPINS-1:0] pad_out,
  input  wire logic [NPINS-1:0] pad_oe,
  input  wire logic [NPINS-1:0] pad_pu,
  input  wire logic [NPINS-1:0] pad_pd,
  input  wire logic [NPINS-1:0] ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic [NPINS-1:0]      pad_in
);
  logic [NPINS-1:0] last_lvl = '0;

  // Last level, so a floating pin can show its inverse
  always @(posedge mclk) begin
    last_lvl <= pad_in;
  end

  // Probe wins, then the port driver, then pulls; floating pins toggle
  // so a stale level never passes for a real one
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (pad_pu[i]) pad_in[i] = 1'b1;
      else if (pad_pd[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~last_lvl[i];
    end
  end
endmodule

// ### debug_shared_gpio_port_tb.sv
// Self-checking bench for the debug-shared GPIO port over AXI4-Lite.
// Assumes the probe model resolves pads; one 25 MHz clock.
`timescale 1ns/1ns
module debug_shared_gpio_port_tb
  import dsg_pkg::*;
;
  logic              mclk = 1'b0;
  logic              nrst = 1'b0;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [ADDR_W-1:0] s_axi_awaddr = '0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_wready;
  logic [31:0]       s_axi_wdata = '0;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_bvalid;
  logic              s_axi_bready = 1'b0;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [ADDR_W-1:0] s_axi_araddr = '0;
  logic              s_axi_rvalid;
  logic              s_axi_rready = 1'b0;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic [NPINS-1:0]  pad_in, pad_out, pad_oe, pad_pu, pad_pd;
  logic [NPINS-1:0]  ext_en = '0;
  logic [NPINS-1:0]  ext_val = '0;
  logic              dbg_tck, dbg_tms, dbg_tdi, dbg_trst_n;
  logic              dbg_swdio_out = 1'b0;
  logic              dbg_swdio_oe = 1'b1;
  logic              dbg_tdo = 1'b0;
  logic              trace_clk = 1'b0;
  logic [1:0]        trace_data = 2'b00;
  logic              deep_stop_mode = 1'b0;
  logic              standby_drive_enable = 1'b0;
  int                failures = 0;
  int                num_checks = 0;

  dsg_port dut_u (.*);
  dsg_probe_model probe_u (.*);

  // 40 ns period
  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic close_out();
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
  endtask

  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    // Pads take their layout one edge late and are sampled one more
    settle();
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(logic [5:0] a, logic [31:0] d, logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (n >= 50) failures++;
  endtask

  // Read and compare data and response
  task automatic rchk(logic [5:0] a, logic [31:0] ed, logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (n < 50) begin
      @(posedge mclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (n >= 50) failures++;
  endtask

  // Reset values, then all-ones writes expose implemented bits only
  task automatic t_regs();
    logic [5:0]  ofs [7] = '{6'h00, 6'h04, 6'h08, 6'h28, 6'h2C, 6'h30,
                             6'h38};
    logic [31:0] rv [7] = '{32'hC0, 32'h30, 32'hF8, 0, 32'hD0, 32'h08,
                            32'hD8};
    logic [31:0] mk [7] = '{32'hE7, 32'hFF, 32'hFF, 32'h07, 32'hF7,
                            32'h08, 32'hFF};
    for (int i = 0; i < 7; i++) begin
      rchk(ofs[i], rv[i], RESP_OKAY);
      wr(ofs[i], 32'hFFFF_FFFF, RESP_OKAY);
      rchk(ofs[i], mk[i], RESP_OKAY);
    end
    // Reserved holes probed on purpose only; traffic stays mapped
    rchk(6'h0C, 32'h0000_0000, RESP_SLVERR);
    wr(6'h34, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  // Debug pins as they come out of reset
  task automatic t_pads();
    @(posedge mclk);
    dbg_tdo <= 1'b1;
    dbg_swdio_out <= 1'b1;
    settle();
    chk("pad_pu", pad_pu, 8'hD0);
    chk("pad_pd", pad_pd, 8'h08);
    chk("pad_oe", pad_oe, 8'h30);
    chk("pad_out", pad_out, 8'h30);
    chk("trst_n", dbg_trst_n, 1'b1);
    chk("tdi", dbg_tdi, 1'b1);
    chk("tck lo", dbg_tck, 1'b0);
    chk("tms hi", dbg_tms, 1'b1);
    @(posedge mclk);
    ext_val <= 8'h08;
    ext_en <= 8'h18; // Probe also pulls pin four low against the port
    settle();
    chk("tck hi", dbg_tck, 1'b1);
    chk("tms lo", dbg_tms, 1'b0);
    @(posedge mclk);
    ext_en <= 8'h00;
  endtask

  // Deep stop keeps only the debug output drivers alive; standby drive keeps all
  task automatic t_stop();
    @(posedge mclk);
    deep_stop_mode <= 1'b1;
    settle();
    chk("stop oe", pad_oe, 8'h30);
    @(posedge mclk);
    dbg_swdio_oe <= 1'b0;
    settle();
    chk("swdio oe", pad_oe, 8'h20);
    @(posedge mclk);
    dbg_swdio_oe <= 1'b1;
    wr(OFS_ALT, 32'h0, RESP_OKAY);
    settle();
    chk("stop port", pad_oe, 8'h00);
    @(posedge mclk);
    standby_drive_enable <= 1'b1;
    settle();
    chk("stby oe", pad_oe, 8'h30);
    @(posedge mclk);
    deep_stop_mode <= 1'b0;
  endtask

  // Port mode drive, gated input path and the trace pins
  task automatic t_port();
    wr(OFS_DRIVE, 32'h81, RESP_OKAY);
    wr(OFS_LEVEL, 32'h01, RESP_OKAY);
    settle();
    chk("port out", pad_out, 8'h01);
    chk("port oe", pad_oe, 8'h81);
    @(posedge mclk);
    ext_val <= 8'h02;
    ext_en <= 8'h02;
    wr(OFS_IE, 32'h00, RESP_OKAY);
    settle();
    rchk(OFS_LEVEL, 32'h01, RESP_OKAY);
    wr(OFS_IE, 32'h03, RESP_OKAY);
    settle();
    rchk(OFS_LEVEL, 32'h03, RESP_OKAY);
    // Open-drain pin zero at level one lets go of the pad
    wr(OFS_OD, 32'h01, RESP_OKAY);
    settle();
    chk("od oe", pad_oe, 8'h80);
    chk("od out", pad_out, 8'h00);
    @(posedge mclk);
    ext_en <= 8'h00;
    trace_clk <= 1'b1;
    trace_data <= 2'b01;
    wr(OFS_DRIVE, 32'h07, RESP_OKAY);
    wr(OFS_ALT, 32'h07, RESP_OKAY);
    settle();
    chk("trace out", pad_out, 8'h06);
  endtask

  // Main sequence; a second reset restores the debug layout
  initial begin
    do_reset();
    t_regs();
    do_reset();
    t_pads();
    t_stop();
    t_port();
    close_out();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #200000;
    failures++;
    close_out();
  end
endmodule
